// ==== verilog/adc_port_regs.vh ====
// Constants of the host register and readout port
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH
`define CMD_WRITE_BIT 15
`define CMD_ADDR_MSB 14
`define CMD_ADDR_LSB 9
`define CMD_DATA_MSB 8
`define CMD_DATA_LSB 0
`define WORD_BITS 16
`define RESULT_BITS 14
`define ADDR_BITS 6
`define DATA_BITS 9
`define REG_COUNT 64
`define REG_RESET 9'h000
`define CONV_TIME_NS 1000
`define CLK_PERIOD_NS 100
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== verilog/pin_sync.v ====
// Two-stage synchroniser for a bundle of pins
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pin_sync

// ==== verilog/conv_timer.v ====
// Conversion timer that holds busy for a fixed count
`timescale 1ns/1ns
`include "adc_port_regs.vh"
module conv_timer #(
  parameter CYCLES = `CONV_CYCLES
) (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire start_in,
  output reg busy_out,
  output reg done_out
);
  reg [15:0] count;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= 16'h0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        count <= CYCLES[15:0];
      end else if (busy_out) begin
        if (count == 16'h0001) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        count <= count - 16'h0001;
      end
    end
  end
endmodule // conv_timer

// ==== verilog/adc_host_port.v ====
// Register and readout port of a dual simultaneous-sampling converter
`timescale 1ns/1ns
`include "adc_port_regs.vh"
// How it works
// - Parallel write is one 16-bit word with bit 15 high.
// - Bits 14..9 hold register address; bits 8..0 hold write data.
// - Parallel command is taken on the rising edge of write strobe.
// - Read command has bit 15 low; its low nine bits are ignored.
// - Parallel read command loads addressed register into output word.
// - Writes take effect only in software mode, from either port.
// - Two-wire mode: A result on first output, B on second.
// - One-wire mode: A then B results on first output.
// - Wire mode is caught three clocks after reset release and held.
// - Convert start rising edge raises busy for the conversion.
// - Chip select fall enables first output (second too in two-wire) and shows the MSB.
// - Later bits shift out on serial clock rising edges.
// - Two-wire word: 14 result bits, then two zeros.
// - One-wire: A word then B word, each with two zeros.
// - With checking on, a full word carries the status register.
// - Serial write uses the same 16-bit command layout.
// - Parallel result on lines 15..2, driven while select and read low.
module adc_host_port #(
  parameter CONV_CYCLES = `CONV_CYCLES
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire nrst_in,
  // Mode pins
  input wire serial_parallel_select_in,
  input wire one_wire_select_in,
  input wire software_mode_in,
  input wire status_append_in,
  // Conversion
  input wire convert_start_in,
  input wire [`RESULT_BITS-1:0] a_side_channel_in,
  input wire [`RESULT_BITS-1:0] b_side_channel_in,
  output reg busy_out,
  // Bus strobes
  input wire cs_n_in,
  input wire rd_n_in,
  input wire wr_n_in,
  input wire sclk_in,
  input wire sdi_in,
  // Parallel data
  input wire [`WORD_BITS-1:0] data_in,
  output reg [`WORD_BITS-1:0] data_out,
  output reg data_oe_out,
  // Serial data
  output reg serial_out_a_out,
  output reg serial_out_a_oe_out,
  output reg serial_out_b_out,
  output reg serial_out_b_oe_out,
  // Status view
  output reg one_wire_mode_out
);
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [5:0] pins_s;
  wire [`WORD_BITS-1:0] data_s;
  wire [3:0] mode_s;
  pin_sync #(.WIDTH(6), .INIT(6'b011_100)) u_sync_ctl (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .async_in({convert_start_in, cs_n_in, rd_n_in, wr_n_in, sclk_in, sdi_in}),
    .sync_out(pins_s)
  );
  pin_sync #(.WIDTH(`WORD_BITS)) u_sync_data (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .async_in(data_in),
    .sync_out(data_s)
  );
  pin_sync #(.WIDTH(4)) u_sync_mode (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .async_in({serial_parallel_select_in, one_wire_select_in, software_mode_in, status_append_in}),
    .sync_out(mode_s)
  );
  wire cst_s = pins_s[5];
  wire cs_n_s = pins_s[4];
  wire rd_n_s = pins_s[3];
  wire wr_n_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire sdi_s = pins_s[0];
  wire ser_sel = mode_s[3];
  wire sw_mode = mode_s[1];
  wire stat_app = mode_s[0];

  ////////////////////////////////////////////////////////////////
  // Edge detection
  reg cst_d;
  reg cs_n_d;
  reg wr_n_d;
  reg sclk_d;
  reg rd_act_d;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cst_d <= 1'b0;
      cs_n_d <= 1'b1;
      wr_n_d <= 1'b1;
      sclk_d <= 1'b0;
      rd_act_d <= 1'b0;
    end else begin
      cst_d <= cst_s;
      cs_n_d <= cs_n_s;
      wr_n_d <= wr_n_s;
      sclk_d <= sclk_s;
      rd_act_d <= !cs_n_s && !rd_n_s;
    end
  end
  wire cst_rise = cst_s && !cst_d;
  wire cs_fall = !cs_n_s && cs_n_d;
  wire wr_rise = wr_n_s && !wr_n_d && !cs_n_s;
  wire sclk_rise = sclk_s && !sclk_d;
  wire sclk_fall = !sclk_s && sclk_d;
  wire rd_act = !cs_n_s && !rd_n_s;
  wire rd_start = rd_act && !rd_act_d;

  ////////////////////////////////////////////////////////////////
  // Wire mode strap caught after reset release
  reg [1:0] strap_cnt;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_cnt <= 2'h0;
      one_wire_mode_out <= 1'b0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h2) begin
        one_wire_mode_out <= !mode_s[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Conversion and result capture
  wire conv_done;
  wire conv_busy;
  conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .start_in(cst_rise),
    .busy_out(conv_busy),
    .done_out(conv_done)
  );
  reg [`RESULT_BITS-1:0] res_a;
  reg [`RESULT_BITS-1:0] res_b;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res_a <= 14'h0000;
      res_b <= 14'h0000;
      busy_out <= 1'b0;
    end else begin
      busy_out <= conv_busy;
      if (conv_done) begin
        res_a <= a_side_channel_in;
        res_b <= b_side_channel_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register file and command decode
  reg [`DATA_BITS-1:0] regs [0:`REG_COUNT-1];
  reg [`DATA_BITS-1:0] status_reg;
  reg [`WORD_BITS-1:0] out_word;
  reg out_is_reg;
  reg ser_rd_pend;
  reg [`ADDR_BITS-1:0] ser_rd_addr;
  reg [`WORD_BITS-1:0] shift_in;
  reg [4:0] in_cnt;
  wire [`WORD_BITS-1:0] ser_word = {shift_in[14:0], sdi_s};
  wire ser_cmd = ser_sel && sclk_fall && !cs_n_s && in_cnt == 5'd15;
  wire par_cmd = !ser_sel && wr_rise;
  wire [`WORD_BITS-1:0] cmd = par_cmd ? data_s : ser_word;
  wire cmd_valid = par_cmd || ser_cmd;
  wire [`ADDR_BITS-1:0] cmd_addr = cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
  wire [`DATA_BITS-1:0] cmd_data = cmd[`CMD_DATA_MSB:`CMD_DATA_LSB];
  wire cmd_wr = cmd[`CMD_WRITE_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi = gi + 1) begin : g_reg
      always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          regs[gi] <= `REG_RESET;
        end else if (cmd_valid && cmd_wr && sw_mode && cmd_addr == gi) begin
          regs[gi] <= cmd_data;
        end
      end
    end
  endgenerate
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_reg <= 9'h000;
      out_word <= 16'h0000;
      out_is_reg <= 1'b0;
      ser_rd_pend <= 1'b0;
      ser_rd_addr <= 6'h00;
    end else begin
      status_reg <= {7'h00, one_wire_mode_out, conv_busy};
      if (conv_done) begin
        out_is_reg <= 1'b0;
      end
      // parallel read latch, data bits ignored
      if (par_cmd && !cmd_wr) begin
        out_word <= {7'h00, regs[cmd_addr]};
        out_is_reg <= 1'b1;
      end
      if (ser_cmd) begin
        ser_rd_pend <= !cmd_wr;
        ser_rd_addr <= cmd_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Parallel output
  reg rd_b_next;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out <= 16'h0000;
      data_oe_out <= 1'b0;
      rd_b_next <= 1'b0;
    end else begin
      // drive only while selected and read
      data_oe_out <= !ser_sel && rd_act;
      if (conv_done) begin
        rd_b_next <= 1'b0;
      end
      if (!ser_sel && rd_start) begin
        if (out_is_reg) begin
          data_out <= out_word;
        end else begin
          data_out <= {rd_b_next ? res_b : res_a, 2'b00};
          rd_b_next <= !rd_b_next;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Serial readout
  reg [4:0] bit_cnt;
  reg [`WORD_BITS-1:0] sh_a;
  reg [`WORD_BITS-1:0] sh_b;
  reg [`WORD_BITS-1:0] next_a;
  reg [`WORD_BITS-1:0] next_b;
  reg half_b;
  always @* begin
    next_a = {res_a, 2'b00};
    next_b = {res_b, 2'b00};
    if (ser_rd_pend) begin
      next_a = {7'h00, regs[ser_rd_addr]};
    // B word follows A in one-wire
    end else if (one_wire_mode_out && half_b) begin
      next_a = {res_b, 2'b00};
    end
  end
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt <= 5'd0;
      in_cnt <= 5'd0;
      shift_in <= 16'h0000;
      sh_a <= 16'h0000;
      sh_b <= 16'h0000;
      half_b <= 1'b0;
      serial_out_a_out <= 1'b0;
      serial_out_b_out <= 1'b0;
      serial_out_a_oe_out <= 1'b0;
      serial_out_b_oe_out <= 1'b0;
    end else begin
      if (conv_done) begin
        half_b <= 1'b0;
      end
      if (!ser_sel || cs_n_s) begin
        serial_out_a_oe_out <= 1'b0;
        serial_out_b_oe_out <= 1'b0;
        in_cnt <= 5'd0;
      end else if (cs_fall) begin
        serial_out_a_oe_out <= 1'b1;
        serial_out_b_oe_out <= !one_wire_mode_out;
        sh_a <= {next_a[14:0], 1'b0};
        sh_b <= {next_b[14:0], 1'b0};
        serial_out_a_out <= next_a[15];
        serial_out_b_out <= next_b[15];
        bit_cnt <= 5'd1;
      end else begin
        if (sclk_fall) begin
          shift_in <= {shift_in[14:0], sdi_s};
          in_cnt <= (in_cnt == 5'd15) ? 5'd0 : in_cnt + 5'd1;
        end
        if (sclk_rise && bit_cnt != 5'd0) begin
          if (bit_cnt == 5'd16) begin
            if (one_wire_mode_out && !half_b && !ser_rd_pend) begin
              serial_out_a_out <= res_b[13];
              sh_a <= {res_b[12:0], 3'b000};
              half_b <= 1'b1;
            end else begin
              half_b <= 1'b0;
              serial_out_a_out <= stat_app ? status_reg[8] : 1'b0;
              sh_a <= stat_app ? {status_reg[7:0], 8'h00} : 16'h0000;
            end
            serial_out_b_out <= stat_app ? status_reg[8] : 1'b0;
            sh_b <= stat_app ? {status_reg[7:0], 8'h00} : 16'h0000;
            bit_cnt <= 5'd17;
          end else begin
            serial_out_a_out <= sh_a[15];
            serial_out_b_out <= sh_b[15];
            sh_a <= {sh_a[14:0], 1'b0};
            sh_b <= {sh_b[14:0], 1'b0};
            bit_cnt <= (bit_cnt == 5'd31) ? 5'd16 : bit_cnt + 5'd1;
          end
        end
      end
    end
  end
endmodule // adc_host_port

// ==== dv/adc_host_port_sva.sv ====
// Port assertions of the host register and readout port
`timescale 1ns/1ns
module adc_host_port_sva #(
  parameter CONV_CYCLES = 10
) (
  // Clock, reset and pins
  input wire sys_clk_in,
  input wire nrst_in,
  input wire serial_parallel_select_in,
  input wire convert_start_in,
  input wire cs_n_in,
  input wire rd_n_in,
  input wire sclk_in,
  // Outputs
  input wire busy_out,
  input wire data_oe_out,
  input wire serial_out_a_out,
  input wire serial_out_a_oe_out,
  input wire serial_out_b_oe_out,
  input wire one_wire_mode_out
);
  localparam int BUSY_LAST = CONV_CYCLES - 1;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);
  chk_sdo_cs_on: assert property ($fell(cs_n_in) && serial_parallel_select_in |-> ##[2:5] serial_out_a_oe_out)
    else $error("serial output not enabled after select");
  chk_sdo_cs_off: assert property (cs_n_in [*5] |-> !serial_out_a_oe_out && !serial_out_b_oe_out)
    else $error("serial output driven while deselected");
  chk_sdo_par_sel: assert property ((!serial_parallel_select_in) [*5] |-> !serial_out_a_oe_out)
    else $error("serial output driven in parallel mode");
  chk_bus_ser_sel: assert property (serial_parallel_select_in [*5] |-> !data_oe_out)
    else $error("parallel bus driven in serial mode");
  chk_bus_oe_off: assert property ((rd_n_in || cs_n_in) [*5] |-> !data_oe_out)
    else $error("parallel bus driven without read");
  chk_bus_oe_on: assert property ((!rd_n_in && !cs_n_in && !serial_parallel_select_in) [*5] |-> data_oe_out)
    else $error("parallel bus not driven during read");
  chk_busy_start: assert property ($rose(convert_start_in) && !busy_out |-> ##[1:5] busy_out)
    else $error("busy not raised by convert start");
  chk_busy_len: assert property ($rose(busy_out) |-> ##BUSY_LAST busy_out ##1 !busy_out)
    else $error("busy length wrong");
  chk_sdo_steady: assert property ((!cs_n_in && $stable(sclk_in)) [*6] |-> $stable(serial_out_a_out))
    else $error("serial output moved without clock edge");
  chk_mode_hold: assert property ($past(nrst_in) && $past(nrst_in, 2) && $past(nrst_in, 3) && $past(nrst_in, 4)
    |-> $stable(one_wire_mode_out))
    else $error("wire mode changed after reset");
  cover property ($fell(busy_out));
  cover property ($rose(serial_out_a_oe_out));
  cover property ($rose(data_oe_out));
endmodule // adc_host_port_sva
bind adc_host_port adc_host_port_sva #(.CONV_CYCLES(CONV_CYCLES)) chk (.sys_clk_in, .nrst_in,
  .serial_parallel_select_in, .convert_start_in, .cs_n_in, .rd_n_in, .sclk_in, .busy_out, .data_oe_out,
  .serial_out_a_out, .serial_out_a_oe_out, .serial_out_b_oe_out, .one_wire_mode_out);

// ==== dv/host_model.sv ====
// Host controller model for the parallel bus and serial port
`timescale 1ns/1ns
module host_model (
  input wire clk_in,
  output reg cs_n_out,
  output reg rd_n_out,
  output reg wr_n_out,
  output reg sclk_out,
  output reg sdi_out,
  output reg [15:0] bus_out,
  input wire [15:0] data_in,
  input wire oe_in,
  input wire sdo_a_in,
  input wire sdo_b_in,
  input wire sdo_a_oe_in,
  input wire sdo_b_oe_in
);
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    bus_out = 16'h0000;
  end
  task pwrite(input [15:0] word);
    begin
      @(posedge clk_in) #3;
      bus_out = word;
      cs_n_out = 1'b0;
      wr_n_out = 1'b0;
      #600;
      wr_n_out = 1'b1;
      #300;
      cs_n_out = 1'b1;
      bus_out = ~word;
      #500;
    end
  endtask
  task pread(output [15:0] word, output oe);
    begin
      @(posedge clk_in) #3;
      cs_n_out = 1'b0;
      rd_n_out = 1'b0;
      #600;
      word = oe_in ? data_in : ~data_in;
      oe = oe_in;
      rd_n_out = 1'b1;
      cs_n_out = 1'b1;
      #800;
    end
  endtask
  task frame(input int n, input [31:0] tx, output [31:0] rxa, output [31:0] rxb);
    int i;
    begin
      @(posedge clk_in) #3;
      rxa = 32'h0000_0000;
      rxb = 32'h0000_0000;
      cs_n_out = 1'b0;
      #600;
      for (i = 0; i < n; i = i + 1) begin
        rxa = {rxa[30:0], sdo_a_oe_in ? sdo_a_in : ~sdo_a_in};
        rxb = {rxb[30:0], sdo_b_oe_in ? sdo_b_in : ~sdo_b_in};
        sdi_out = tx[n - 1 - i];
        sclk_out = 1'b1;
        #400;
        sclk_out = 1'b0;
        #400;
      end
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out;
      #800;
    end
  endtask
endmodule // host_model

// ==== dv/test_adc_host_port.sv ====
// Self-checking bench of the host register and readout port
`timescale 1ns/1ns
module test_adc_host_port;
  reg sys_clk_in, nrst_in, serial_parallel_select_in, one_wire_select_in, software_mode_in, convert_start_in;
  reg [13:0] a_side_channel_in, b_side_channel_in;
  wire cs_n_in, rd_n_in, wr_n_in, sclk_in, sdi_in, busy_out, data_oe_out, one_wire_mode_out;
  wire serial_out_a_out, serial_out_a_oe_out, serial_out_b_out, serial_out_b_oe_out;
  wire [15:0] data_in, data_out;
  reg [15:0] lfsr, got;
  reg [31:0] rxa, rxb;
  reg [8:0] val;
  reg [5:0] adr;
  reg oe;
  reg [8:0] model_regs [0:63];
  reg [15:0] exp_q [$];
  integer bad_count, n_checks, k;
  adc_host_port #(.CONV_CYCLES(10)) uut (.sys_clk_in, .nrst_in, .serial_parallel_select_in, .one_wire_select_in,
    .software_mode_in, .status_append_in(1'b0), .convert_start_in, .a_side_channel_in, .b_side_channel_in,
    .busy_out, .cs_n_in, .rd_n_in, .wr_n_in, .sclk_in, .sdi_in, .data_in, .data_out, .data_oe_out,
    .serial_out_a_out, .serial_out_a_oe_out, .serial_out_b_out, .serial_out_b_oe_out, .one_wire_mode_out);
  host_model host (.clk_in(sys_clk_in), .cs_n_out(cs_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
    .sclk_out(sclk_in), .sdi_out(sdi_in), .bus_out(data_in), .data_in(data_out), .oe_in(data_oe_out),
    .sdo_a_in(serial_out_a_out), .sdo_b_in(serial_out_b_out), .sdo_a_oe_in(serial_out_a_oe_out),
    .sdo_b_oe_in(serial_out_b_oe_out));
  function [15:0] next_rand(input [15:0] s);
    next_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input string name, input [31:0] exp, input [31:0] seen);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task do_reset(input sel);
    begin
      nrst_in = 1'b0;
      one_wire_select_in = sel;
      for (k = 0; k < 64; k = k + 1) model_regs[k] = 9'h000;
      repeat (8) @(posedge sys_clk_in);
      #3 nrst_in = 1'b1;
      repeat (2) @(posedge sys_clk_in);
      #3 one_wire_select_in = ~sel;
      repeat (4) @(posedge sys_clk_in);
      #3 check("wire mode", !sel, one_wire_mode_out);
    end
  endtask
  task convert;
    begin
      lfsr = next_rand(lfsr);
      a_side_channel_in = lfsr[13:0];
      lfsr = next_rand(lfsr);
      b_side_channel_in = lfsr[13:0];
      exp_q.push_back({a_side_channel_in, 2'b00});
      exp_q.push_back({b_side_channel_in, 2'b00});
      @(posedge sys_clk_in) #3 convert_start_in = 1'b1;
      repeat (5) @(posedge sys_clk_in);
      #3 convert_start_in = 1'b0;
      check("busy high", 1, busy_out);
      for (k = 0; k < 30 && busy_out !== 1'b0; k = k + 1) @(posedge sys_clk_in);
      #3 check("busy low", 0, busy_out);
    end
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    {bad_count, n_checks, lfsr} = {32'd0, 32'd0, 16'h0001};
    {serial_parallel_select_in, software_mode_in, convert_start_in} = 3'b110;
    {a_side_channel_in, b_side_channel_in} = 28'h000_0000;
    do_reset(1'b1);
    convert;
    host.frame(16, 32'hffff_ffff, rxa, rxb);
    check("two wire a", exp_q.pop_front(), rxa);
    check("two wire b", exp_q.pop_front(), rxb);
    $display("test serial two wire done");
    serial_parallel_select_in = 1'b0;
    convert;
    for (k = 0; k < 2; k = k + 1) begin
      host.pread(got, oe);
      check("parallel result", exp_q.pop_front(), got);
      check("parallel oe", 1, oe);
    end
    $display("test parallel result done");
    adr = lfsr[5:0];
    val = lfsr[14:6];
    model_regs[adr] = val;
    host.pwrite({1'b1, adr, val});
    software_mode_in = 1'b0;
    host.pwrite({1'b1, adr, ~val});
    host.pwrite({1'b0, adr, lfsr[8:0]});
    host.pread(got, oe);
    check("parallel register", {7'h00, model_regs[adr]}, got);
    $display("test parallel register done");
    {software_mode_in, serial_parallel_select_in} = 2'b11;
    adr = adr + 6'h01;
    val = ~val;
    model_regs[adr] = val;
    repeat (5) @(posedge sys_clk_in);
    host.frame(16, {16'h0000, 1'b1, adr, val}, rxa, rxb);
    host.frame(16, {16'h0000, 1'b0, adr, 9'h1ff}, rxa, rxb);
    host.frame(16, 32'h0000_0000, rxa, rxb);
    check("serial register", {7'h00, model_regs[adr]}, rxa);
    $display("test serial register done");
    do_reset(1'b0);
    convert;
    host.frame(32, 32'hffff_ffff, rxa, rxb);
    got = exp_q.pop_front();
    check("one wire pair", {got, exp_q.pop_front()}, rxa);
    convert;
    for (k = 0; k < 2; k = k + 1) begin
      host.frame(16, 32'hffff_ffff, rxa, rxb);
      check("one wire split", exp_q.pop_front(), rxa);
    end
    $display("test serial one wire done");
    give_verdict;
  end
endmodule // test_adc_host_port
